// ===== hw/cam_pkg.sv
// package: register map, field positions and bus carriers of the counter array
package cam_pkg;
    localparam int CAM_NUM_MOD = 8;
    localparam int CAM_NUM_CAP = 6;
    // per-module register block: byte address = module * 16 + register offset
    localparam logic [7:0] CAM_OFS_MODE = 8'h00;
    localparam logic [7:0] CAM_OFS_CMP_LO = 8'h04;
    localparam logic [7:0] CAM_OFS_CMP_HI = 8'h08;
    localparam logic [7:0] CAM_OFS_AUX = 8'h0C;
    localparam logic [7:0] CAM_MOD_STRIDE = 8'h10;
    // global registers
    localparam logic [7:0] CAM_OFS_CTRL = 8'h80;
    localparam logic [7:0] CAM_OFS_COUNT = 8'h84;
    // module mode register fields
    localparam int CAM_M_PAIR_D = 7;
    localparam int CAM_M_CMP_EN = 6;
    localparam int CAM_M_CAP_RISE = 5;
    localparam int CAM_M_CAP_FALL = 4;
    localparam int CAM_M_MATCH = 3;
    localparam int CAM_M_TOGGLE = 2;
    localparam int CAM_M_PWM = 1;
    localparam int CAM_M_IRQ_EN = 0;
    // auxiliary register fields
    localparam int CAM_A_RES = 6;
    localparam int CAM_A_FLAG = 3;
    localparam int CAM_A_BUF9 = 1;
    localparam int CAM_A_ACT9 = 0;
    localparam logic [7:0] CAM_AUX_WMASK = 8'hC3;
    // control register fields
    localparam int CAM_C_RUN = 0;
    localparam int CAM_C_PAIR_A = 1;
    localparam int CAM_C_PAIR_B = 2;
    localparam int CAM_C_PAIR_C = 3;
    localparam int CAM_C_FSRC = 4;
    localparam logic [7:0] CAM_CTRL_WMASK = 8'h3F;
    // reset values
    localparam logic [7:0] CAM_RST_BYTE = 8'h00;
    localparam logic [15:0] CAM_RST_COUNT = 16'h0000;
    // resolution select encodings
    localparam logic [1:0] CAM_RES_8 = 2'b00;
    localparam logic [1:0] CAM_RES_10 = 2'b01;
    localparam logic [1:0] CAM_RES_12 = 2'b10;
    localparam logic [1:0] CAM_RES_16 = 2'b11;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } cam_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cam_apb_rsp_t;

    typedef struct packed {
        logic timer_zero_overflow;
        logic timer_one_overflow;
        logic timer_three_overflow;
        logic serial_zero_baud_overflow;
    } cam_step_t;
endpackage : cam_pkg

// ===== hw/cam_top.sv
// eight compare/pwm modules, capture on modules 0..5 only, around one shared 16-bit counter
// Contract
// - valid pin edge copies counter into compare bytes
// - irq only when flag and enable set
// - odd modules buffer even captures when paired
// - pair enables join modules 0/1, 2/3, 4/5
// - timer mode: counter equals compare sets flag
// - toggle mode inverts pin on each match
// - all pwm share the one counter frequency
// - 8-bit pwm low while low byte below active
// - active value reloads at low byte rollover
// - duty equals one minus buffered over 256
// - resolution 00 gives buffered 8-bit pwm
// - resolutions 01/10/11 give 10/12/16 bits, unbuffered unless paired
// - pwm-match toggle mode toggles on pwm comparator
// - paired pwm-match: even sets, odd clears
// - modules 6/7 pair via module 6 bit
// - fifo mode chains four compare bytes
// - step source select picks overflow event
// - fifo: n pwm reloads, n+1 shifts
// - mode bit combinations select module functions
// - flag set by hardware, cleared by software
module cam_top #(
    parameter int NUM_MOD = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // register bus
    input cam_pkg::cam_apb_req_t apb_req,
    output cam_pkg::cam_apb_rsp_t apb_rsp,
    // module pins: input, output, output enable (low while driving)
    input wire logic [7:0] module_pin_in,
    output logic [7:0] module_pin_out,
    output logic [7:0] module_pin_oe_n,
    // fifo step events, one-cycle pulses
    input cam_pkg::cam_step_t step_in,
    // array interrupt request
    output logic irq
);
    import cam_pkg::*;

    if (NUM_MOD != CAM_NUM_MOD) begin : g_check
        $error("cam_top serves exactly eight modules");
    end

    // register state
    logic [7:0] mode [8];
    logic [7:0] cmp_lo [8];
    logic [7:0] cmp_hi [8];
    logic [7:0] aux [8];
    logic [16:0] act [8];
    logic [7:0] ctrl;
    logic [15:0] counter;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_prev;

    // per-module decoded function and events
    logic [7:0] is_cap, is_cmp, is_pwm, is_pwm_match_toggle_mode, is_fifo, paired;
    logic [7:0] cap_hit, cmp_hit, pwm_hit, period_end, pwm_lvl, hit;
    logic [16:0] eff [8];
    logic [3:0] pair_bit;
    logic fifo_step;

    // width mask of the counter for a resolution select
    function automatic logic [15:0] cam_mask(input logic [1:0] res);
        case (res)
            CAM_RES_8: cam_mask = 16'h00FF;
            CAM_RES_10: cam_mask = 16'h03FF;
            CAM_RES_12: cam_mask = 16'h0FFF;
            default: cam_mask = 16'hFFFF;
        endcase
    endfunction : cam_mask

    // compare value with its extension bit placed just above the width
    function automatic logic [16:0] cam_ext(input logic [1:0] res,
                                            input logic top,
                                            input logic [15:0] val);
        logic [15:0] m;
        m = cam_mask(res);
        cam_ext = {1'b0, val & m} + {m, 1'b1} - {m, 1'b0} + {16'h0000, 1'b0};
        cam_ext = {1'b0, val & m} | (top ? ({1'b0, m} + 17'h0_0001) : 17'h0);
    endfunction : cam_ext

    // bus decode
    wire logic [2:0] sel_mod = apb_req.paddr[6:4];
    wire logic [7:0] sel_ofs = {4'h0, apb_req.paddr[3:0]};
    wire logic in_mod = ~apb_req.paddr[7];
    wire logic hit_ctrl = apb_req.paddr == CAM_OFS_CTRL;
    wire logic hit_count = apb_req.paddr == CAM_OFS_COUNT;
    wire logic mapped = in_mod | hit_ctrl | hit_count;
    wire logic setup_ph = apb_req.psel & ~apb_req.penable & ~apb_rsp.pready;
    wire logic wr_en = apb_req.psel & apb_req.penable & apb_rsp.pready
                       & apb_req.pwrite;
    wire logic [7:0] wbyte = apb_req.pwdata[7:0];
    wire logic wr_mode = wr_en & in_mod & (sel_ofs == CAM_OFS_MODE);
    wire logic wr_lo = wr_en & in_mod & (sel_ofs == CAM_OFS_CMP_LO);
    wire logic wr_hi = wr_en & in_mod & (sel_ofs == CAM_OFS_CMP_HI);
    wire logic wr_aux = wr_en & in_mod & (sel_ofs == CAM_OFS_AUX);
    wire logic wr_ctrl = wr_en & hit_ctrl;
    logic [7:0] rd_mod;
    always_comb begin
        case (sel_ofs)
            CAM_OFS_MODE: rd_mod = mode[sel_mod];
            CAM_OFS_CMP_LO: rd_mod = cmp_lo[sel_mod];
            CAM_OFS_CMP_HI: rd_mod = cmp_hi[sel_mod];
            default: rd_mod = aux[sel_mod];
        endcase
    end
    wire logic [31:0] rd_word = in_mod ? {24'h00_0000, rd_mod}
                              : hit_ctrl ? {24'h00_0000, ctrl}
                              : hit_count ? {16'h0000, counter} : 32'h0000_0000;

    // pairing bits; the 6/7 bit lives in the module 6 mode register
    assign pair_bit = {mode[6][CAM_M_PAIR_D],
                       ctrl[CAM_C_PAIR_C], ctrl[CAM_C_PAIR_B],
                       ctrl[CAM_C_PAIR_A]};

    // step event source for fifo chains
    wire logic [1:0] fsrc = ctrl[CAM_C_FSRC +: 2];
    assign fifo_step = (fsrc == 2'b00) ? step_in.timer_zero_overflow
                     : (fsrc == 2'b01) ? step_in.timer_one_overflow
                     : (fsrc == 2'b10) ? step_in.timer_three_overflow
                     : step_in.serial_zero_baud_overflow;

    // per-module decode, comparators and pwm level
    for (genvar g = 0; g < 8; g++) begin : g_mod
        wire logic [7:0] m = mode[g];
        wire logic [1:0] res = aux[g][CAM_A_RES +: 2];
        wire logic [15:0] msk = cam_mask(res);
        wire logic [16:0] cnt_w = {1'b0, counter & msk};
        wire logic rise = pin_s2[g] & ~pin_prev[g];
        wire logic fall = ~pin_s2[g] & pin_prev[g];
        // capture only on modules 0..5 with the pwm, match and toggle bits clear
        assign is_cap[g] = (m[CAM_M_CAP_RISE] | m[CAM_M_CAP_FALL])
                           & ~m[CAM_M_PWM] & ~m[CAM_M_MATCH]
                           & ~m[CAM_M_TOGGLE] & (g < CAM_NUM_CAP);
        assign is_cmp[g] = m[CAM_M_CMP_EN] & m[CAM_M_MATCH]
                           & ~m[CAM_M_PWM];
        assign is_pwm[g] = m[CAM_M_CMP_EN] & m[CAM_M_PWM];
        assign is_pwm_match_toggle_mode[g] = is_pwm[g] & m[CAM_M_TOGGLE];
        assign is_fifo[g] = is_pwm[g] & m[CAM_M_CAP_FALL]
                            & ~m[CAM_M_TOGGLE] & (g % 2 == 0);
        assign paired[g] = pair_bit[g / 2];
        assign cap_hit[g] = is_cap[g] & ((m[CAM_M_CAP_RISE] & rise)
                            | (m[CAM_M_CAP_FALL] & fall));
        assign cmp_hit[g] = is_cmp[g]
                            & (counter == {cmp_hi[g], cmp_lo[g]});
        assign period_end[g] = (counter & msk) == msk;
        // 8-bit is always buffered; wide is buffered only when paired
        assign eff[g] = (res == CAM_RES_8 || paired[g]) ? act[g]
                        : cam_ext(res, aux[g][CAM_A_ACT9],
                                  {cmp_hi[g], cmp_lo[g]});
        assign pwm_lvl[g] = ~(cnt_w < eff[g]);
        assign pwm_hit[g] = is_pwm_match_toggle_mode[g] & (cnt_w == eff[g]);
        assign hit[g] = cap_hit[g] | (cmp_hit[g] & m[CAM_M_MATCH])
                        | pwm_hit[g];
    end

    // shared free-running counter clocks every pwm alike
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            counter <= CAM_RST_COUNT;
        end else if (ctrl[CAM_C_RUN]) begin
            counter <= counter + 16'h0001;
        end
    end

    // two-stage synchroniser, then a third stage for edge detection
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pin_s1 <= CAM_RST_BYTE;
            pin_s2 <= CAM_RST_BYTE;
            pin_prev <= CAM_RST_BYTE;
        end else begin
            pin_s1 <= module_pin_in;
            pin_s2 <= pin_s1;
            pin_prev <= pin_s2;
        end
    end

    // control and mode registers, written by software only
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl <= CAM_RST_BYTE;
            for (int n = 0; n < 8; n++) begin
                mode[n] <= CAM_RST_BYTE;
            end
        end else begin
            if (wr_ctrl) begin
                ctrl <= wbyte & CAM_CTRL_WMASK;
            end
            if (wr_mode) begin
                mode[sel_mod] <= wbyte;
            end
        end
    end

    // aux: software fields plus the event flag; a set beats a clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int n = 0; n < 8; n++) begin
                aux[n] <= CAM_RST_BYTE;
            end
        end else begin
            for (int n = 0; n < 8; n++) begin
                if (wr_aux && sel_mod == n[2:0]) begin
                    aux[n] <= (wbyte & CAM_AUX_WMASK)
                              | {4'h0, aux[n][CAM_A_FLAG] & wbyte[CAM_A_FLAG],
                                 3'b000};
                end
                if (hit[n]) begin
                    aux[n][CAM_A_FLAG] <= 1'b1;
                end
            end
        end
    end

    // compare bytes: software writes, captures, pair buffer, fifo shift;
    // hardware events win over a software write in the same cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int n = 0; n < 8; n++) begin
                cmp_lo[n] <= CAM_RST_BYTE;
                cmp_hi[n] <= CAM_RST_BYTE;
            end
        end else begin
            for (int n = 0; n < 8; n++) begin
                if (wr_lo && sel_mod == n[2:0]) begin
                    cmp_lo[n] <= wbyte;
                end
                if (wr_hi && sel_mod == n[2:0]) begin
                    cmp_hi[n] <= wbyte;
                end
                if (cap_hit[n]) begin
                    {cmp_hi[n], cmp_lo[n]} <= counter;
                end
            end
            for (int p = 0; p < 3; p++) begin
                // odd module keeps the even one's previous capture
                if (paired[2 * p] && cap_hit[2 * p]) begin
                    cmp_hi[2 * p + 1] <= cmp_hi[2 * p];
                    cmp_lo[2 * p + 1] <= cmp_lo[2 * p];
                end
            end
            for (int p = 0; p < 4; p++) begin
                // chain: (n+1) high -> (n+1) low -> n low -> n high
                if (is_fifo[2 * p] && fifo_step) begin
                    cmp_hi[2 * p] <= cmp_lo[2 * p];
                    cmp_lo[2 * p] <= cmp_lo[2 * p + 1];
                    cmp_lo[2 * p + 1] <= cmp_hi[2 * p + 1];
                end
            end
        end
    end

    // active pwm compare value reloads at the end of each period
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int n = 0; n < 8; n++) begin
                act[n] <= 17'h0_0000;
            end
        end else begin
            for (int n = 0; n < 8; n++) begin
                if (period_end[n] && ctrl[CAM_C_RUN]) begin
                    act[n] <= (aux[n][CAM_A_RES +: 2] == CAM_RES_8)
                        ? {8'h00, aux[n][CAM_A_BUF9], cmp_hi[n]}
                        : cam_ext(aux[n][CAM_A_RES +: 2], aux[n][CAM_A_BUF9],
                                  {cmp_hi[n], cmp_lo[n]});
                end
            end
        end
    end

    // pin drive: pwm level, toggle on match, paired set/clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            module_pin_out <= CAM_RST_BYTE;
            module_pin_oe_n <= 8'hFF;
        end else begin
            for (int n = 0; n < 8; n++) begin
                module_pin_oe_n[n] <= ~((is_cmp[n] & mode[n][CAM_M_TOGGLE])
                                        | is_pwm[n]);
                if (is_pwm_match_toggle_mode[n]) begin
                    if (pwm_hit[n]) begin
                        module_pin_out[n] <= ~module_pin_out[n];
                    end
                end else if (is_pwm[n]) begin
                    module_pin_out[n] <= pwm_lvl[n];
                end else if (cmp_hit[n] && mode[n][CAM_M_TOGGLE]) begin
                    module_pin_out[n] <= ~module_pin_out[n];
                end
            end
            for (int p = 0; p < 4; p++) begin
                // even match marks the start, odd match the end
                if (paired[2 * p] && is_pwm_match_toggle_mode[2 * p]) begin
                    if (pwm_hit[2 * p]) begin
                        module_pin_out[2 * p] <= 1'b1;
                    end else if (is_pwm_match_toggle_mode[2 * p + 1] && pwm_hit[2 * p + 1]) begin
                        module_pin_out[2 * p] <= 1'b0;
                    end
                end
            end
        end
    end

    // interrupt request from enabled flags
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= 1'b0;
            for (int n = 0; n < 8; n++) begin
                if (aux[n][CAM_A_FLAG] && mode[n][CAM_M_IRQ_EN]) begin
                    irq <= 1'b1;
                end
            end
        end
    end

    // apb slave: answer registered in setup, one access cycle, no waits
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp.pready <= setup_ph;
            apb_rsp.pslverr <= setup_ph & ~mapped;
            apb_rsp.prdata <= (setup_ph & ~apb_req.pwrite) ? rd_word
                              : 32'h0000_0000;
        end
    end
endmodule : cam_top

// ===== test/cam_pin_model.sv
// far-side pin model: resolves each module pin from both drivers
module cam_pin_model (
    // levels that the outside world applies while the module is quiet
    input wire logic [7:0] ext_drive,
    // module side of the split pin
    input wire logic [7:0] module_pin_out,
    input wire logic [7:0] module_pin_oe_n,
    output logic [7:0] module_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // the module wins where it drives, so no contention reaches the input
    assign module_pin_in = (~module_pin_oe_n & module_pin_out)
        | (module_pin_oe_n & ext_drive);
endmodule : cam_pin_model

// ===== test/cam_chk_sva.sv
// checker: register bus timing properties at the counter array top
module cam_chk #(
    parameter int NUM_MOD = 8
) (
    // clock, reset, bus and outputs
    input wire logic ref_clk,
    input wire logic srst,
    input cam_pkg::cam_apb_req_t apb_req,
    input cam_pkg::cam_apb_rsp_t apb_rsp,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import cam_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    // setup cycle of a transfer
    wire logic setup_phase = apb_req.psel && !apb_req.penable;
    a_ready_after_setup: assert property (setup_phase |=> apb_rsp.pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready held too long");
    a_ready_in_access: assert property
        (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
        else $error("ready outside access");
    a_err_unmapped: assert property
        (setup_phase && apb_req.paddr >= 8'h88 |=> apb_rsp.pslverr)
        else $error("unmapped not refused");
    a_no_err_mapped: assert property (setup_phase && apb_req.paddr < 8'h88
        && apb_req.paddr[1:0] == 2'b00 |=> !apb_rsp.pslverr)
        else $error("mapped refused");
    a_err_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error without ready");
    a_quiet_data: assert property (!apb_rsp.pready |-> apb_rsp.prdata == '0)
        else $error("data outside answer");
    a_upper_zero: assert property
        (apb_rsp.pready |-> apb_rsp.prdata[31:8] == '0)
        else $error("upper data bits set");
    // main scenarios reached
    cover property (apb_req.pwrite && apb_rsp.pready);
    cover property (apb_rsp.pslverr);
    cover property ($rose(irq));
endmodule : cam_chk

bind cam_top cam_chk #(.NUM_MOD(NUM_MOD)) i_cam_chk (
    .ref_clk(ref_clk),
    .srst(srst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .irq(irq)
);

// ===== test/tb_top.sv
// bench: capture, timer, toggle, pwm duty and fifo chain of the array
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cam_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    cam_apb_req_t apb_req = '0;
    cam_apb_rsp_t apb_rsp;
    cam_step_t step_in = '0;
    // fall-only capture modules 0 and 3 start with the pin high
    logic [7:0] ext_drive = 8'h09;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
    logic irq;
    logic last_err;
    logic [31:0] seed = 32'h0000_f6c6;
    int miscompares = 0;
    int n_tests = 0;
    logic [31:0] exp_q[$];
    logic [8:0] duty_tab [4] = '{9'h000, 9'h040, 9'h0C0, 9'h100};

    cam_top #(.NUM_MOD(8)) i_cam_top (.ref_clk(ref_clk), .srst(srst),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .module_pin_in(pin_in),
        .module_pin_out(pin_out), .module_pin_oe_n(pin_oe_n),
        .step_in(step_in), .irq(irq));
    cam_pin_model i_cam_pin_model (.ext_drive(ext_drive),
        .module_pin_out(pin_out), .module_pin_oe_n(pin_oe_n),
        .module_pin_in(pin_in));

    always #10 ref_clk = ~ref_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // one transfer; an idle edge first so no signal is assigned twice
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        apb_req <= '{1'b1, 1'b0, wr, a, 32'(d)};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        q = apb_rsp.prdata[7:0];
        last_err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    // note the expected byte; the monitor compares when the answer comes
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        exp_q.push_back(32'(e));
        apb(1'b0, a, 8'h00, q);
    endtask : rd

    function automatic logic [7:0] ra(input int m, input logic [7:0] o);
        return 8'(m * 16) + o;
    endfunction : ra

    // monitor: oldest note against each completed read
    always @(posedge ref_clk)
        if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1
            && !apb_req.pwrite && exp_q.size() > 0)
            chk(apb_rsp.prdata, exp_q.pop_front());

    // watchdog, well beyond the few thousand cycles the run needs
    initial begin
        repeat (40000) @(posedge ref_clk);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        logic [15:0] c;
        logic [8:0] d;
        logic [7:0] v [4];
        logic [3:0] sel;
        logic [7:0] q;
        int hi;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        // reset values, read-only counter and an unmapped place
        rd(CAM_OFS_CTRL, 8'h00);
        rd(ra(3, CAM_OFS_AUX), 8'h00);
        wr(CAM_OFS_COUNT, 8'h55);
        rd(CAM_OFS_COUNT, 8'h00);
        rd(8'h90, 8'h00);
        chk(32'(last_err), 32'h0000_0001);
        // capture: m%3 gives fall, rise, both; odd modules enable irq
        for (int m = 0; m < 6; m++) begin
            wr(ra(m, CAM_OFS_MODE), 8'((m % 3 + 1) * 16 + m % 2));
            wr(CAM_OFS_CTRL, 8'h01);
            repeat (4 + ($random(seed) & 15)) @(posedge ref_clk);
            wr(CAM_OFS_CTRL, 8'h00);
            apb(1'b0, CAM_OFS_COUNT, 8'h00, q);
            ext_drive[m] <= ~ext_drive[m];
            repeat (6) @(posedge ref_clk);
            rd(ra(m, CAM_OFS_CMP_LO), q);
            rd(ra(m, CAM_OFS_CMP_HI), 8'h00);
            rd(ra(m, CAM_OFS_AUX), 8'h08);
            chk(32'(irq), 32'(m % 2));
            wr(ra(m, CAM_OFS_AUX), 8'h00);
            ext_drive[m] <= ~ext_drive[m];
            repeat (6) @(posedge ref_clk);
            rd(ra(m, CAM_OFS_AUX), m % 3 == 2 ? 8'h08 : 8'h00);
        end
        // module 5 toggles, 6 flags at count+20, 7 is far off
        c = {8'h00, q} + 16'h0014;
        for (int m = 5; m < 8; m++) begin
            wr(ra(m, CAM_OFS_CMP_LO), m == 7 ? 8'h00 : c[7:0]);
            wr(ra(m, CAM_OFS_CMP_HI), m == 7 ? 8'h80 : c[15:8]);
            wr(ra(m, CAM_OFS_AUX), 8'h00);
            wr(ra(m, CAM_OFS_MODE), m == 5 ? 8'h4C : 8'h48);
        end
        wr(CAM_OFS_CTRL, 8'h01);
        repeat (60) @(posedge ref_clk);
        wr(CAM_OFS_CTRL, 8'h00);
        rd(ra(6, CAM_OFS_AUX), 8'h08);
        rd(ra(7, CAM_OFS_AUX), 8'h00);
        chk(32'(pin_out[5]), 32'h0000_0001);
        chk(32'(pin_oe_n[5]), 32'h0000_0000);
        // buffered 8-bit pwm on module 0: high cycles in one period
        wr(ra(0, CAM_OFS_MODE), 8'h42);
        wr(CAM_OFS_CTRL, 8'h01);
        for (int k = 0; k < 5; k++) begin
            d = k < 4 ? duty_tab[k] : {1'b0, 8'($random(seed))};
            wr(ra(0, CAM_OFS_CMP_HI), d[7:0]);
            wr(ra(0, CAM_OFS_AUX), {6'h00, d[8], 1'b0});
            repeat (600) @(posedge ref_clk);
            hi = 0;
            repeat (256) begin
                @(posedge ref_clk);
                hi += pin_out[0];
            end
            chk(32'(hi), 32'(256 - d));
        end
        // buffered 10-bit pwm on paired module 4: both bytes, then reload
        wr(CAM_OFS_CTRL, 8'h09);
        wr(ra(4, CAM_OFS_AUX), 8'h40);
        wr(ra(4, CAM_OFS_CMP_LO), 8'h00);
        wr(ra(4, CAM_OFS_CMP_HI), 8'h02);
        wr(ra(4, CAM_OFS_MODE), 8'h42);
        repeat (1100) @(posedge ref_clk);
        hi = 0;
        repeat (1024) begin
            @(posedge ref_clk);
            hi += pin_out[4];
        end
        chk(32'(hi), 32'h0000_0200);
        // fifo chain on modules 2 and 3, one step from each source
        wr(ra(2, CAM_OFS_MODE), 8'h52);
        for (int s = 0; s < 4; s++) begin
            wr(CAM_OFS_CTRL, 8'(s * 16 + 1));
            for (int j = 0; j < 4; j++) begin
                v[j] = 8'($random(seed));
                wr(ra(2 + j / 2, j % 2 ? CAM_OFS_CMP_HI : CAM_OFS_CMP_LO),
                   v[j]);
            end
            // unselected sources first: they must not move the chain
            sel = 4'b1000 >> s;
            step_in <= cam_step_t'(~sel);
            @(posedge ref_clk);
            step_in <= cam_step_t'(sel);
            @(posedge ref_clk);
            step_in <= '0;
            rd(ra(2, CAM_OFS_CMP_HI), v[0]);
            rd(ra(2, CAM_OFS_CMP_LO), v[2]);
        end
        tally_and_finish();
    end
endmodule : tb_top
